// ---- hdl/bprd_addr_seq.sv ----
`timescale 1ns/1ps
`default_nettype none

module bprd_addr_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control from the read master
    bprd_seq_if.seq sb
);

    logic [31:0] addr_reg;
    logic [1:0] beat_reg;

    assign sb.addr = addr_reg;
    assign sb.beat = beat_reg;

    // ------------------------------------------------------------
    // Address: only the long-word index moves, so the byte
    // offset survives follow-on cycles
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_reg <= '0;
        end else if (sb.load) begin
            addr_reg <= sb.load_addr;
        end else if (sb.step) begin
            // Two-bit index wraps inside the 16-byte block
            addr_reg[bprd_pkg::LW_IDX_MSB:bprd_pkg::LW_IDX_LSB] <=
                addr_reg[bprd_pkg::LW_IDX_MSB:bprd_pkg::LW_IDX_LSB] + bprd_pkg::BEAT_STEP;
        end
    end

    // ------------------------------------------------------------
    // Beat counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            beat_reg <= bprd_pkg::BEAT_FIRST;
        end else if (sb.load) begin
            beat_reg <= bprd_pkg::BEAT_FIRST;
        end else if (sb.count) begin
            beat_reg <= beat_reg + bprd_pkg::BEAT_STEP;
        end
    end

endmodule : bprd_addr_seq

`default_nettype wire

// ---- hdl/bprd_read_master.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Contract
// - Single reads ignore slave cache-inhibit when latching.
// - Noncachable, disabled, locked, alternate, non-allocating classes use single reads.
// - First cycle drives valid address, user page bits, type and modifier.
// - Reads drive read/write high; single reads assert cache-inhibit-out.
// - Start strobe asserted in first cycle; in-progress asserted unless already.
// - Start strobe lasts exactly one clock.
// - Acknowledge sampled each clock after first; data latched only on it.
// - In-progress held if next cycle ready, else negated next clock.
// - Fills and block moves read four long words of a 16-byte block.
// - Address and attributes stay stable through a burst; four acknowledged beats.
// - Burst-inhibit on first beat makes master finish with three long reads.
// - Burst-inhibited line is indivisible; no other access or arbitration.
// - Burst-inhibit is evaluated only with the first beat's acknowledge.
// - Cache-inhibit on first line beat is latched and forwarded.
// - Cache-inhibit ignored after first beat and in inhibited follow-ons.
// - Line reads keep original low byte offset through follow-on cycles.
// - Instruction fetches are aligned to a half-line boundary.
// - Line reads use line size; cache-inhibit-out only for noncachable block move.
// - Zero-wait burst line takes five clocks, inhibited line eight.
// - Later beats latched on acknowledge, otherwise wait and resample.
// ------------------------------------------------------------

module bprd_read_master (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Read requests from the memory units
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [31:0] REQ_ADDR,
    input wire logic [1:0] REQ_SIZE,
    input wire logic [2:0] REQ_CLASS,
    input wire logic REQ_NONCACHE,
    input wire logic [1:0] REQ_USER,
    input wire logic [1:0] REQ_TYPE,
    input wire logic [2:0] REQ_MOD,
    // Read responses to the memory units
    output logic RSP_VALID,
    output logic [31:0] RSP_DATA,
    output logic RSP_CACHE_INHIBIT,
    output logic RSP_LINE,
    output logic RSP_LAST,
    output logic [1:0] RSP_BEAT,
    // Bus address and attributes
    output logic [31:0] ADDR_OUT,
    output logic SIZE_CODE_HIGH,
    output logic SIZE_CODE_LOW,
    output logic RW_OUT,
    output logic [1:0] USER_PAGE_ATTRIBUTE_OUT,
    output logic [1:0] TRANSFER_TYPE_OUT,
    output logic [2:0] TRANSFER_MODIFIER_OUT,
    output logic CACHE_INHIBIT_OUT_N,
    // Bus strobes
    output logic TRANSFER_START_STROBE_N,
    output logic TRANSFER_IN_PROGRESS_N,
    output logic LINE_LOCK_OUT,
    // Bus inputs from the slave
    input wire logic [31:0] DATA_IN,
    input wire logic TRANSFER_ACKNOWLEDGE_IN_N,
    input wire logic SLAVE_BURST_INHIBIT_IN_N,
    input wire logic SLAVE_CACHE_INHIBIT_IN_N
);

    // ------------------------------------------------------------
    // Types and signals
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_DATA
    } bprd_state_e;

    bprd_state_e state_reg;
    bprd_state_e state_next;

    logic line_reg;
    logic inhib_reg;
    logic line_ci_reg;

    logic [1:0] size_reg;
    logic rw_reg;
    logic [1:0] user_reg;
    logic [1:0] type_reg;
    logic [2:0] mod_reg;
    logic ci_out_n_reg;

    logic start_n_reg;
    logic prog_n_reg;

    logic rsp_valid_reg;
    logic [31:0] rsp_data_reg;
    logic rsp_ci_reg;
    logic rsp_line_reg;
    logic rsp_last_reg;
    logic [1:0] rsp_beat_reg;

    logic ack_in;
    logic burst_inh_in;
    logic cache_inh_in;
    logic ack;
    logic first_beat;
    logic line_more;
    logic inhib_now;
    logic inhibited;
    logic follow_on;
    logic take;
    logic line_class;
    logic take_line;
    logic take_insn;
    logic take_ci_out;
    logic [1:0] take_size;
    logic [31:0] take_addr;

    bprd_seq_if seq_bus ();

    bprd_addr_seq u_seq (
        .clk(CLK),
        .resetn(RESETN),
        .sb(seq_bus.seq)
    );

    // ------------------------------------------------------------
    // Bus sampling
    // ------------------------------------------------------------
    // Bus inputs share CLK, so they are sampled directly;
    // a synchroniser would break zero-wait beats.
    assign ack_in = !TRANSFER_ACKNOWLEDGE_IN_N;
    assign burst_inh_in = !SLAVE_BURST_INHIBIT_IN_N;
    assign cache_inh_in = !SLAVE_CACHE_INHIBIT_IN_N;

    // Acknowledge counts only after the start clock
    assign ack = (state_reg == ST_DATA) && ack_in;
    assign first_beat = (seq_bus.beat == bprd_pkg::BEAT_FIRST);
    assign line_more = line_reg && (seq_bus.beat != bprd_pkg::BEAT_LAST);
    assign inhib_now = line_reg && first_beat && burst_inh_in;
    assign inhibited = inhib_reg || inhib_now;
    assign follow_on = ack && line_more && inhibited;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Only fills and block moves may burst; all other classes
    // fall back to a single transfer.
    assign line_class = (REQ_CLASS == bprd_pkg::CLS_FILL_DATA)
                     || (REQ_CLASS == bprd_pkg::CLS_FILL_INSN)
                     || (REQ_CLASS == bprd_pkg::CLS_BLOCK_MOVE);
    assign take_line = line_class && (REQ_SIZE == bprd_pkg::SZ_LINE);
    assign take_insn = (REQ_CLASS == bprd_pkg::CLS_FILL_INSN);

    always_comb begin
        if (take_line) begin
            take_size = bprd_pkg::SZ_LINE;
        end else if (REQ_SIZE == bprd_pkg::SZ_LINE) begin
            take_size = bprd_pkg::SZ_LONG;
        end else begin
            take_size = REQ_SIZE;
        end
    end

    always_comb begin
        if (take_line) begin
            take_ci_out = (REQ_CLASS == bprd_pkg::CLS_BLOCK_MOVE) && REQ_NONCACHE;
        end else begin
            take_ci_out = 1'b1;
        end
    end

    // Lines keep the byte offset; fetches go half-line
    assign take_addr = take_insn ? (REQ_ADDR & ~bprd_pkg::HALF_LINE_MASK)
                                 : REQ_ADDR;

    // New requests wait until the line is done, so nothing
    // slips between the cycles of an inhibited line.
    assign REQ_READY = (state_reg == ST_IDLE) || (ack && !line_more);
    assign take = REQ_VALID && REQ_READY;

    assign seq_bus.load = take;
    assign seq_bus.load_addr = take_addr;
    assign seq_bus.step = follow_on;
    assign seq_bus.count = ack;

    // ------------------------------------------------------------
    // Cycle sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                state_next = ST_DATA;
            end
            ST_DATA: begin
                if (!ack) begin
                    state_next = ST_DATA;
                end else if (line_more && !inhibited) begin
                    state_next = ST_DATA;
                end else if (line_more) begin
                    state_next = ST_START;
                end else if (take) begin
                    state_next = ST_START;
                end else begin
                    state_next = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Line bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            line_reg <= 1'b0;
        end else if (take) begin
            line_reg <= take_line;
        end else if (ack && !line_more) begin
            line_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            inhib_reg <= 1'b0;
        end else if (take) begin
            inhib_reg <= 1'b0;
        end else if (ack && inhib_now) begin
            inhib_reg <= 1'b1;
        end
    end

    // Line cache-inhibit is caught once and replayed per beat
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            line_ci_reg <= 1'b0;
        end else if (take) begin
            line_ci_reg <= 1'b0;
        end else if (ack && line_reg && first_beat) begin
            line_ci_reg <= cache_inh_in;
        end
    end

    // ------------------------------------------------------------
    // Address attributes
    // ------------------------------------------------------------
    // Loaded once per request; follow-on cycles of an inhibited
    // line only drop the size to long word.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            size_reg <= bprd_pkg::RST_SIZE;
            rw_reg <= bprd_pkg::RST_RW;
            user_reg <= '0;
            type_reg <= '0;
            mod_reg <= '0;
            ci_out_n_reg <= 1'b1;
        end else if (take) begin
            size_reg <= take_size;
            rw_reg <= 1'b1;
            user_reg <= REQ_USER;
            type_reg <= REQ_TYPE;
            mod_reg <= REQ_MOD;
            ci_out_n_reg <= !take_ci_out;
        end else if (follow_on) begin
            size_reg <= bprd_pkg::SZ_LONG;
        end
    end

    // ------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            start_n_reg <= 1'b1;
        end else begin
            // Low only in the clock that opens a cycle
            start_n_reg <= (state_next != ST_START);
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            prog_n_reg <= 1'b1;
        end else begin
            // Low across back-to-back cycles
            prog_n_reg <= (state_next == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Responses
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_valid_reg <= 1'b0;
            rsp_last_reg <= 1'b0;
            rsp_line_reg <= 1'b0;
            rsp_beat_reg <= bprd_pkg::BEAT_FIRST;
        end else begin
            rsp_valid_reg <= ack;
            rsp_last_reg <= ack && !line_more;
            rsp_line_reg <= ack && line_reg;
            rsp_beat_reg <= seq_bus.beat;
        end
    end

    // Data without acknowledge is never latched
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_data_reg <= '0;
        end else if (ack) begin
            rsp_data_reg <= DATA_IN;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rsp_ci_reg <= 1'b0;
        end else if (ack) begin
            if (!line_reg) begin
                rsp_ci_reg <= 1'b0;
            end else if (first_beat) begin
                rsp_ci_reg <= cache_inh_in;
            end else begin
                rsp_ci_reg <= line_ci_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ADDR_OUT = seq_bus.addr;
    assign SIZE_CODE_HIGH = size_reg[1];
    assign SIZE_CODE_LOW = size_reg[0];
    assign RW_OUT = rw_reg;
    assign USER_PAGE_ATTRIBUTE_OUT = user_reg;
    assign TRANSFER_TYPE_OUT = type_reg;
    assign TRANSFER_MODIFIER_OUT = mod_reg;
    assign CACHE_INHIBIT_OUT_N = ci_out_n_reg;
    assign TRANSFER_START_STROBE_N = start_n_reg;
    assign TRANSFER_IN_PROGRESS_N = prog_n_reg;
    // Holds off arbitration for the rest of a line
    assign LINE_LOCK_OUT = line_reg;

    assign RSP_VALID = rsp_valid_reg;
    assign RSP_DATA = rsp_data_reg;
    assign RSP_CACHE_INHIBIT = rsp_ci_reg;
    assign RSP_LINE = rsp_line_reg;
    assign RSP_LAST = rsp_last_reg;
    assign RSP_BEAT = rsp_beat_reg;

endmodule : bprd_read_master

`default_nettype wire

// ---- include/bprd_pkg.sv ----
`default_nettype none

package bprd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;

    // ------------------------------------------------------------
    // Size codes {high, low}
    // ------------------------------------------------------------
    localparam logic [1:0] SZ_LONG = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LINE = 2'h3;

    // ------------------------------------------------------------
    // Line geometry
    // ------------------------------------------------------------
    localparam int unsigned LW_IDX_LSB = 2;
    localparam int unsigned LW_IDX_MSB = 3;
    localparam logic [1:0] BEAT_FIRST = 2'h0;
    localparam logic [1:0] BEAT_LAST = 2'h3;
    localparam logic [1:0] BEAT_STEP = 2'h1;
    localparam logic [31:0] HALF_LINE_MASK = 32'h0000_0007;

    // ------------------------------------------------------------
    // Reset values of the attribute pins
    // ------------------------------------------------------------
    localparam logic RST_RW = 1'b1;
    localparam logic [1:0] RST_SIZE = SZ_LONG;

    // ------------------------------------------------------------
    // Access classes presented with a request
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_FILL_DATA,
        CLS_FILL_INSN,
        CLS_BLOCK_MOVE,
        CLS_NONCACHE,
        CLS_CACHE_OFF,
        CLS_RMW,
        CLS_ALT_SPACE,
        CLS_NO_ALLOC
    } bprd_class_e;

endpackage : bprd_pkg

`default_nettype wire

// ---- include/bprd_seq_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface bprd_seq_if;
    logic load;
    logic [31:0] load_addr;
    logic step;
    logic count;
    logic [31:0] addr;
    logic [1:0] beat;

    modport ctrl (output load, output load_addr, output step, output count,
                  input addr, input beat);
    modport seq (input load, input load_addr, input step, input count,
                 output addr, output beat);
endinterface : bprd_seq_if

`default_nettype wire

// ---- test/bprd_read_master_props.sv ----
`timescale 1ns/1ps
`default_nettype none

module bprd_read_master_props (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Requests and responses
    input wire logic REQ_VALID,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire logic [31:0] RSP_DATA,
    input wire logic RSP_CACHE_INHIBIT,
    input wire logic RSP_LINE,
    input wire logic RSP_LAST,
    // Bus side
    input wire logic [31:0] ADDR_OUT,
    input wire logic SIZE_CODE_HIGH,
    input wire logic SIZE_CODE_LOW,
    input wire logic RW_OUT,
    input wire logic CACHE_INHIBIT_OUT_N,
    input wire logic TRANSFER_START_STROBE_N,
    input wire logic TRANSFER_IN_PROGRESS_N,
    input wire logic LINE_LOCK_OUT,
    input wire logic [31:0] DATA_IN,
    input wire logic TRANSFER_ACKNOWLEDGE_IN_N,
    input wire logic SLAVE_BURST_INHIBIT_IN_N
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic is_line;
    logic acked;
    assign is_line = {SIZE_CODE_HIGH, SIZE_CODE_LOW} == bprd_pkg::SZ_LINE;
    assign acked = !TRANSFER_ACKNOWLEDGE_IN_N && !TRANSFER_IN_PROGRESS_N;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    AST_START_ONE_CLK: assert property ($fell(TRANSFER_START_STROBE_N)
        |=> TRANSFER_START_STROBE_N)
        else $error("start too long");
    AST_START_IN_PROG: assert property (!TRANSFER_START_STROBE_N
        |-> !TRANSFER_IN_PROGRESS_N)
        else $error("start without prog");
    AST_READ_DIR: assert property (!TRANSFER_START_STROBE_N |-> RW_OUT)
        else $error("write direction");
    AST_LATCH_ON_ACK: assert property (RSP_VALID |->
        !$past(TRANSFER_ACKNOWLEDGE_IN_N) && RSP_DATA == $past(DATA_IN))
        else $error("unacked response");
    AST_ACK_TO_RSP: assert property (acked && TRANSFER_START_STROBE_N |=> RSP_VALID)
        else $error("ack lost");
    AST_PROG_DROP: assert property (acked && REQ_READY && !REQ_VALID
        |=> TRANSFER_IN_PROGRESS_N)
        else $error("prog held");
    AST_PROG_KEEP: assert property (acked && REQ_READY && REQ_VALID
        |=> !TRANSFER_IN_PROGRESS_N && !TRANSFER_START_STROBE_N)
        else $error("prog dropped");
    AST_LINE_STABLE: assert property (is_line && TRANSFER_START_STROBE_N
        && !TRANSFER_IN_PROGRESS_N |-> $stable(ADDR_OUT))
        else $error("address moved");
    AST_BURST_FIVE: assert property (!TRANSFER_START_STROBE_N && is_line ##1
        (!TRANSFER_ACKNOWLEDGE_IN_N && SLAVE_BURST_INHIBIT_IN_N) [*4] |=> RSP_VALID && RSP_LAST)
        else $error("burst too slow");
    AST_INHIBIT_NEXT: assert property (!TRANSFER_START_STROBE_N && is_line ##1
        (!TRANSFER_ACKNOWLEDGE_IN_N && !SLAVE_BURST_INHIBIT_IN_N) |=> !TRANSFER_START_STROBE_N
        && !is_line && ADDR_OUT[3:2] == $past(ADDR_OUT[3:2]) + 2'h1
        && ADDR_OUT[1:0] == $past(ADDR_OUT[1:0]))
        else $error("bad follow-on");
    AST_SINGLE_CI: assert property (!TRANSFER_START_STROBE_N && !LINE_LOCK_OUT
        |-> !CACHE_INHIBIT_OUT_N)
        else $error("single cached");
    AST_SINGLE_NO_SCI: assert property (RSP_VALID && !RSP_LINE |-> !RSP_CACHE_INHIBIT)
        else $error("single took inhibit");
endmodule : bprd_read_master_props

bind bprd_read_master bprd_read_master_props u_props (.CLK(CLK), .RESETN(RESETN),
    .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA),
    .RSP_CACHE_INHIBIT(RSP_CACHE_INHIBIT), .RSP_LINE(RSP_LINE), .RSP_LAST(RSP_LAST),
    .ADDR_OUT(ADDR_OUT), .SIZE_CODE_HIGH(SIZE_CODE_HIGH), .SIZE_CODE_LOW(SIZE_CODE_LOW),
    .RW_OUT(RW_OUT), .CACHE_INHIBIT_OUT_N(CACHE_INHIBIT_OUT_N),
    .TRANSFER_START_STROBE_N(TRANSFER_START_STROBE_N),
    .TRANSFER_IN_PROGRESS_N(TRANSFER_IN_PROGRESS_N), .LINE_LOCK_OUT(LINE_LOCK_OUT),
    .DATA_IN(DATA_IN), .TRANSFER_ACKNOWLEDGE_IN_N(TRANSFER_ACKNOWLEDGE_IN_N),
    .SLAVE_BURST_INHIBIT_IN_N(SLAVE_BURST_INHIBIT_IN_N));

`default_nettype wire

// ---- test/bprd_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module bprd_slave_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Bus from the master
    input wire logic start_n,
    input wire logic [31:0] addr,
    input wire logic [1:0] size,
    // Answers
    output logic [31:0] data,
    output logic ack_n,
    output logic burst_inh_n,
    output logic cache_inh_n,
    // Bench knobs
    input wire logic [3:0] waits,
    input wire logic no_burst,
    input wire logic ci_first,
    input wire logic ci_later
);
    logic [31:0] a;
    logic first;
    int left = 0, cnt = 0;

    initial {data, ack_n, burst_inh_n, cache_inh_n} = '1;

    always @(posedge clk) begin
        if (ack_n == 1'b0) begin
            left = left - 1;
            a[3:2] = a[3:2] + 2'h1;
            first = 1'b0;
            cnt = int'(waits);
        end
        if (start_n == 1'b0) begin
            a = addr;
            first = (size == bprd_pkg::SZ_LINE);
            left = (first && !no_burst) ? 4 : 1;
            cnt = int'(waits);
        end
        if (!resetn) left = 0;
        #1;
        {ack_n, burst_inh_n, cache_inh_n} = 3'h7;
        // Idle bus churns so stale data cannot pass
        data = ~data;
        if (left > 0 && cnt > 0) begin
            cnt = cnt - 1;
        end else if (left > 0) begin
            ack_n = 1'b0;
            data = {a[31:2], 2'h0} ^ 32'ha5a5_0000;
            burst_inh_n = !(no_burst && first);
            cache_inh_n = first ? !ci_first : !ci_later;
        end
    end
endmodule : bprd_slave_model

`default_nettype wire

// ---- test/processor_bus_read_cycles_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module processor_bus_read_cycles_tb_top;
    logic clk = 1'b0;
    logic rstn, rq_v, rq_rdy, rq_nc, rs_v, rs_ci, rs_ln, rs_last, sz_h, sz_l, rw, ci_n;
    logic st_n, ip_n, lock, ack_n, bi_n, ci_in, no_burst, ci_first, ci_later;
    logic [31:0] rq_a, rs_d, a_out, d_in;
    logic [1:0] rq_sz, rq_u, rq_t, rs_beat, pattr, xtype;
    logic [2:0] rq_cls, rq_m, xmod;
    logic [3:0] waits;
    int mismatches = 0;
    int comparisons = 0;

    always #25 clk = ~clk;

    bprd_read_master uut (.CLK(clk), .RESETN(rstn), .REQ_VALID(rq_v), .REQ_READY(rq_rdy),
        .REQ_ADDR(rq_a), .REQ_SIZE(rq_sz), .REQ_CLASS(rq_cls), .REQ_NONCACHE(rq_nc),
        .REQ_USER(rq_u), .REQ_TYPE(rq_t), .REQ_MOD(rq_m), .RSP_VALID(rs_v), .RSP_DATA(rs_d),
        .RSP_CACHE_INHIBIT(rs_ci), .RSP_LINE(rs_ln), .RSP_LAST(rs_last), .RSP_BEAT(rs_beat),
        .ADDR_OUT(a_out), .SIZE_CODE_HIGH(sz_h), .SIZE_CODE_LOW(sz_l), .RW_OUT(rw),
        .USER_PAGE_ATTRIBUTE_OUT(pattr), .TRANSFER_TYPE_OUT(xtype), .TRANSFER_MODIFIER_OUT(xmod),
        .CACHE_INHIBIT_OUT_N(ci_n), .TRANSFER_START_STROBE_N(st_n),
        .TRANSFER_IN_PROGRESS_N(ip_n), .LINE_LOCK_OUT(lock), .DATA_IN(d_in),
        .TRANSFER_ACKNOWLEDGE_IN_N(ack_n), .SLAVE_BURST_INHIBIT_IN_N(bi_n),
        .SLAVE_CACHE_INHIBIT_IN_N(ci_in));

    bprd_slave_model slave (.clk(clk), .resetn(rstn), .start_n(st_n), .addr(a_out),
        .size({sz_h, sz_l}), .data(d_in), .ack_n(ack_n), .burst_inh_n(bi_n),
        .cache_inh_n(ci_in), .waits(waits), .no_burst(no_burst), .ci_first(ci_first),
        .ci_later(ci_later));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [31:0] eff(input logic [31:0] a, input logic [2:0] cls);
        return (cls == bprd_pkg::CLS_FILL_INSN) ? (a & ~bprd_pkg::HALF_LINE_MASK) : a;
    endfunction : eff

    task automatic req(input logic [31:0] a, input logic [1:0] sz, input logic [2:0] cls,
            input logic nc, input logic exp_ci_n);
        logic ln;
        ln = (sz == bprd_pkg::SZ_LINE) && (cls <= bprd_pkg::CLS_BLOCK_MOVE);
        {rq_v, rq_a, rq_sz, rq_cls, rq_nc} = {1'b1, a, sz, cls, nc};
        {rq_u, rq_t, rq_m} = a[10:4];
        @(negedge clk);
        for (int i = 0; i < 300 && rq_rdy !== 1'b1; i++) @(negedge clk);
        @(posedge clk) #1;
        rq_v = 1'b0;
        check({st_n, ip_n}, 2'h0);
        check(a_out, eff(a, cls));
        check({pattr, xtype, xmod}, a[10:4]);
        check({sz_h, sz_l}, (sz == bprd_pkg::SZ_LINE && !ln) ? bprd_pkg::SZ_LONG : sz);
        check(ci_n, exp_ci_n);
    endtask : req

    // Clock counts run from raising the request
    task automatic rsp(input logic [31:0] a, input logic [2:0] cls, input int nb,
            input logic ci, input int clks);
        logic [31:0] e;
        time t0;
        e = eff(a, cls);
        t0 = $time;
        for (int k = 0; k < nb; k++) begin
            for (int i = 0; i < 300 && rs_v !== 1'b1; i++) @(posedge clk) #1;
            check({rs_ln, rs_last, rs_beat, rs_ci}, {nb == 4, k == nb - 1, 2'(k), ci});
            check(rs_d, {e[31:4], e[3:2] + 2'(k), 2'h0} ^ 32'ha5a5_0000);
            if (k == nb - 1 && clks > 0) check(32'(($time - t0) / 50), clks);
            @(posedge clk) #1;
        end
    endtask : rsp

    task automatic run(input logic [31:0] a, input logic [1:0] sz, input logic [2:0] cls,
            input logic nc, input logic ci_nx, input int nb, input logic ci, input int clks);
        fork
            req(a, sz, cls, nc, ci_nx);
            rsp(a, cls, nb, ci, clks);
        join
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        check({st_n, ip_n, ci_n, rw, rq_rdy, rs_v, lock}, 7'b1111100);
    endtask : t_reset

    task automatic t_single;
        {no_burst, ci_first, ci_later} = 3'h3;
        for (int c = 3; c < 8; c++) begin
            waits = 4'(c % 3);
            run(32'h0000_2043 + 32'(c << 12), 2'(c), 3'(c), 1'b0, 1'b0, 1, 1'b0, 3 + c % 3);
        end
        waits = 4'h0;
        run(32'h0000_3346, bprd_pkg::SZ_LONG, bprd_pkg::CLS_FILL_INSN, 0, 0, 1, 0, 3);
    endtask : t_single

    task automatic t_burst;
        {waits, no_burst, ci_first, ci_later} = 7'h01;
        run(32'h0001_004e, bprd_pkg::SZ_LINE, bprd_pkg::CLS_BLOCK_MOVE, 0, 1, 4, 0, 6);
        {waits, ci_first, ci_later} = 6'h0a;
        run(32'h0001_1084, bprd_pkg::SZ_LINE, bprd_pkg::CLS_FILL_DATA, 0, 1, 4, 1, 14);
    endtask : t_burst

    // A waiting request must not split the line
    task automatic t_inhibit;
        {waits, no_burst, ci_first, ci_later} = 7'h05;
        fork
            begin
                req(32'h1000_000c, bprd_pkg::SZ_LINE, bprd_pkg::CLS_FILL_INSN, 0, 1);
                @(posedge clk) #1;
                req(32'h0000_5012, bprd_pkg::SZ_WORD, bprd_pkg::CLS_RMW, 0, 0);
            end
            begin
                rsp(32'h1000_000c, bprd_pkg::CLS_FILL_INSN, 4, 0, 9);
                rsp(32'h0000_5012, bprd_pkg::CLS_RMW, 1, 0, 0);
            end
        join
        run(32'h0002_0039, bprd_pkg::SZ_LINE, bprd_pkg::CLS_BLOCK_MOVE, 1, 0, 4, 0, 9);
    endtask : t_inhibit

    task automatic results;
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        {rq_v, rq_a, rq_sz, rq_cls, rq_nc, rq_u, rq_t, rq_m} = '0;
        {waits, no_burst, ci_first, ci_later} = '0;
        rstn = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_single();
        t_burst();
        t_inhibit();
        results();
    end

    initial begin
        #(4000 * 50);
        mismatches++;
        results();
    end
endmodule : processor_bus_read_cycles_tb_top

`default_nettype wire
